// >>> core/scb_cfg.svh
// register map, field positions, reset values of the config bank
`ifndef SCB_CFG_SVH
`define SCB_CFG_SVH
`define SCB_ADDR_W           8
`define SCB_OFF_NMI_MASK0    8'h00
`define SCB_OFF_NMI_MASK1    8'h04
`define SCB_OFF_PROC_CONFIG  8'h08
`define SCB_OFF_BYPASS_LOW   8'h0C
`define SCB_OFF_BYPASS_HIGH  8'h10
`define SCB_OFF_DEBUG_FORCE  8'h14
`define SCB_OFF_MEM_PWRDN    8'h18
`define SCB_ID1_MSB          31
`define SCB_ID1_LSB          28
`define SCB_ID0_MSB          27
`define SCB_ID0_LSB          24
`define SCB_ID1_RESET        4'h1
`define SCB_ID0_RESET        4'h0
`define SCB_HALT1_BIT        1
`define SCB_HALT0_BIT        0
`define SCB_GPIO_LOW_N       30
`define SCB_GPIO_HIGH_N      6
`define SCB_GPIO_N           36
`define SCB_DBG_RESET        8'h66
`define SCB_DBG_WMASK        8'hEE
`define SCB_MEM_N            8
`define SCB_SYNC_STAGES      2
`endif

// >>> core/scb_pkg.sv
// shared types of the config bank
package scb_pkg;
   typedef enum logic [2:0] {
      SCB_IDLE = 3'b001,
      SCB_RESP = 3'b010,
      SCB_DONE = 3'b100
   } scb_bus_state_e;
   typedef logic [31:0] scb_word_t;
endpackage

// >>> core/scb_debug_if.sv
// per-core debug port steering bundle
`timescale 1ns/1ps
`default_nettype none
interface scb_debug_if;
   logic attach;
   logic clk_drive;
   logic din_drive;
   logic pad_clk;
   logic pad_din;
   logic core_clk;
   logic core_din;
   modport ctrl (output attach, output clk_drive, output din_drive);
   modport mux  (input attach, input clk_drive, input din_drive,
                 input pad_clk, input pad_din,
                 output core_clk, output core_din);
endinterface
`default_nettype wire

// >>> core/scb_debug_mux.sv
// registered debug port selector for one core
`timescale 1ns/1ps
`default_nettype none
module scb_debug_mux (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // steering
   scb_debug_if.mux  dbg
);
   // registered so the core sees a glitch-free select; costs one cycle
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dbg.core_clk <= 1'b1;
         dbg.core_din <= 1'b1;
      end else if (dbg.attach) begin
         dbg.core_clk <= dbg.clk_drive;
         dbg.core_din <= dbg.din_drive;
      end else begin
         dbg.core_clk <= dbg.pad_clk;
         dbg.core_din <= dbg.pad_din;
      end
   end
endmodule // scb_debug_mux
`default_nettype wire

// >>> core/scb_gpio_sync.sv
// per-pin input synchroniser with bypass
`timescale 1ns/1ps
`default_nettype none
`include "scb_cfg.svh"
module scb_gpio_sync (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     resetn,
   // pins and control
   input  wire logic [`SCB_GPIO_N-1:0]   pin_in,
   input  wire logic [`SCB_GPIO_N-1:0]   bypass,
   // to gpio input register
   output logic      [`SCB_GPIO_N-1:0]   gpio_in
);
   logic [`SCB_GPIO_N-1:0] stage_a;
   logic [`SCB_GPIO_N-1:0] stage_b;
   genvar g;
   generate
      for (g = 0; g < `SCB_GPIO_N; g = g + 1) begin : g_pin
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               stage_a[g] <= 1'b0;
               stage_b[g] <= 1'b0;
               gpio_in[g] <= 1'b0;
            end else begin
               stage_a[g] <= pin_in[g];
               stage_b[g] <= stage_a[g];
               // bypass skips both stages: two cycles sooner [RULE6]
               gpio_in[g] <= bypass[g] ? pin_in[g] : stage_b[g];
            end
         end
      end
   endgenerate
endmodule // scb_gpio_sync
`default_nettype wire

// >>> core/scb_bank.sv
// system configuration register bank, avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
`include "scb_cfg.svh"
// How it works
// RULE1: core 1 instance id bits 31:28, reset 1
// RULE2: core 0 instance id bits 27:24, reset 0
// RULE3: software never writes instance id 15
// RULE4: halted flags read-only at bits 1, 0
// RULE5: low bypass skips synchroniser, gpio 0-29
// RULE6: bypassed path arrives two cycles earlier
// RULE7: high bypass covers gpio 30-35, bits 5:0
// RULE8: software keeps synchronisers on unless synchronous
// RULE9: attach bit 7 moves core 1 port inside
// RULE10: bit 6 drives core 1 debug clock
// RULE11: bit 5 drives core 1 debug data in
// RULE12: bit 4 shows core 1 debug data out
// RULE13: same controls for core 0, bits 3:0
// RULE14: power-down bits: rom, usb, six srams
// RULE15: per-core 32-bit nmi source masks, reset zero
// RULE16: reserved bits read zero, ignore writes
module scb_bank (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      resetn,
   // avalon-mm slave
   input  wire logic [`SCB_ADDR_W-1:0]    avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [31:0]               avs_writedata,
   input  wire logic [3:0]                avs_byteenable,
   output logic      [31:0]               avs_readdata,
   output logic      [1:0]                avs_response,
   output logic                           avs_waitrequest,
   // core status
   input  wire logic                      core0_halted,
   input  wire logic                      core1_halted,
   input  wire logic                      core0_debug_data_out,
   input  wire logic                      core1_debug_data_out,
   // external debug pads
   input  wire logic                      pad0_debug_clock,
   input  wire logic                      pad0_debug_data_in,
   input  wire logic                      pad1_debug_clock,
   input  wire logic                      pad1_debug_data_in,
   // debug ports to cores
   output logic                           core0_debug_clock,
   output logic                           core0_debug_data_in,
   output logic                           core1_debug_clock,
   output logic                           core1_debug_data_in,
   output logic      [3:0]                core0_debug_instance_id,
   output logic      [3:0]                core1_debug_instance_id,
   // gpio input path
   input  wire logic [`SCB_GPIO_N-1:0]    gpio_pin_in,
   output logic      [`SCB_GPIO_N-1:0]    gpio_in_value,
   // nmi and memories
   output logic      [31:0]               core0_nmi_source_mask,
   output logic      [31:0]               core1_nmi_source_mask,
   output logic      [`SCB_MEM_N-1:0]     memory_power_down
);
   scb_pkg::scb_bus_state_e       state;
   logic [`SCB_GPIO_LOW_N-1:0]    bypass_low;
   logic [`SCB_GPIO_HIGH_N-1:0]   bypass_high;
   logic [7:0]                    dbg_ctl;
   logic [1:0]                    halt_s1;
   logic [1:0]                    halt_s2;
   logic [1:0]                    dout_s1;
   logic [1:0]                    dout_s2;
   scb_pkg::scb_word_t            next_readdata;
   logic                          hit;
   logic                          do_write;
   logic [31:0]                   bmask;

   scb_debug_if dbg0 ();
   scb_debug_if dbg1 ();

   // byte-lane mask from the avalon byte enables
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic addr_hit(input logic [`SCB_ADDR_W-1:0] a);
      unique case (a)
         `SCB_OFF_NMI_MASK0, `SCB_OFF_NMI_MASK1, `SCB_OFF_PROC_CONFIG,
         `SCB_OFF_BYPASS_LOW, `SCB_OFF_BYPASS_HIGH, `SCB_OFF_DEBUG_FORCE,
         `SCB_OFF_MEM_PWRDN: addr_hit = 1'b1;
         default:            addr_hit = 1'b0;
      endcase
   endfunction

   assign bmask    = lane_mask(avs_byteenable);
   assign hit      = addr_hit(avs_address);
   // write commits once, on the idle-to-response edge
   assign do_write = avs_write && (state == scb_pkg::SCB_IDLE);

   // status pins are async to us; two flops before use
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         halt_s1 <= 2'h0;
         halt_s2 <= 2'h0;
         dout_s1 <= 2'h0;
         dout_s2 <= 2'h0;
      end else begin
         halt_s1 <= {core1_halted, core0_halted};
         halt_s2 <= halt_s1;
         dout_s1 <= {core1_debug_data_out, core0_debug_data_out};
         dout_s2 <= dout_s1;
      end
   end

   // bus handshake: one wait cycle, then release
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state           <= scb_pkg::SCB_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         unique case (state)
            scb_pkg::SCB_IDLE: if (avs_read || avs_write) begin
               state           <= scb_pkg::SCB_RESP;
               avs_waitrequest <= 1'b0;
            end
            scb_pkg::SCB_RESP: begin
               state           <= scb_pkg::SCB_DONE;
               avs_waitrequest <= 1'b1;
            end
            scb_pkg::SCB_DONE: state <= scb_pkg::SCB_IDLE;
            default: begin
               state           <= scb_pkg::SCB_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // writable fields; reserved bits are never stored
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         core1_debug_instance_id <= `SCB_ID1_RESET;
         core0_debug_instance_id <= `SCB_ID0_RESET;
         bypass_low              <= '0;
         bypass_high             <= '0;
         dbg_ctl                 <= `SCB_DBG_RESET;
         memory_power_down       <= '0;
         core0_nmi_source_mask   <= 32'h00000000;
         core1_nmi_source_mask   <= 32'h00000000;
      end else if (do_write) begin
         unique case (avs_address)
            `SCB_OFF_NMI_MASK0: core0_nmi_source_mask <=
               (core0_nmi_source_mask & ~bmask) |
               (avs_writedata & bmask);                        // [RULE15]
            `SCB_OFF_NMI_MASK1: core1_nmi_source_mask <=
               (core1_nmi_source_mask & ~bmask) |
               (avs_writedata & bmask);                        // [RULE15]
            `SCB_OFF_PROC_CONFIG: if (avs_byteenable[3]) begin
               // value 15 is not trapped; software keeps clear of it
               core1_debug_instance_id <=
                  avs_writedata[`SCB_ID1_MSB:`SCB_ID1_LSB];   // [RULE1] [RULE3]
               core0_debug_instance_id <=
                  avs_writedata[`SCB_ID0_MSB:`SCB_ID0_LSB];   // [RULE2]
            end
            `SCB_OFF_BYPASS_LOW: bypass_low <=
               (bypass_low & ~bmask[`SCB_GPIO_LOW_N-1:0]) |
               (avs_writedata[`SCB_GPIO_LOW_N-1:0]
                & bmask[`SCB_GPIO_LOW_N-1:0]);                 // [RULE5]
            `SCB_OFF_BYPASS_HIGH: if (avs_byteenable[0])
               bypass_high <= avs_writedata[`SCB_GPIO_HIGH_N-1:0]; // [RULE7]
            `SCB_OFF_DEBUG_FORCE: if (avs_byteenable[0])
               // data-out view bits 4 and 0 are read-only
               dbg_ctl <= (dbg_ctl & ~`SCB_DBG_WMASK) |
                  (avs_writedata[7:0] & `SCB_DBG_WMASK);      // [RULE9] [RULE13]
            `SCB_OFF_MEM_PWRDN: if (avs_byteenable[0])
               memory_power_down <= avs_writedata[7:0];       // [RULE14]
            default: ;
         endcase
      end
   end

   // read mux; reserved and unmapped bits return zero
   always_comb begin
      next_readdata = '0;
      unique case (avs_address)
         `SCB_OFF_NMI_MASK0:   next_readdata = core0_nmi_source_mask;
         `SCB_OFF_NMI_MASK1:   next_readdata = core1_nmi_source_mask;
         `SCB_OFF_PROC_CONFIG: begin
            next_readdata[`SCB_ID1_MSB:`SCB_ID1_LSB] =
               core1_debug_instance_id;
            next_readdata[`SCB_ID0_MSB:`SCB_ID0_LSB] =
               core0_debug_instance_id;
            next_readdata[`SCB_HALT1_BIT] = halt_s2[1];        // [RULE4]
            next_readdata[`SCB_HALT0_BIT] = halt_s2[0];        // [RULE4]
         end
         `SCB_OFF_BYPASS_LOW:
            next_readdata[`SCB_GPIO_LOW_N-1:0] = bypass_low;
         `SCB_OFF_BYPASS_HIGH:
            next_readdata[`SCB_GPIO_HIGH_N-1:0] = bypass_high;
         `SCB_OFF_DEBUG_FORCE: begin
            next_readdata[7:0] = dbg_ctl;
            next_readdata[4]   = dout_s2[1];                   // [RULE12]
            next_readdata[0]   = dout_s2[0];                   // [RULE13]
         end
         `SCB_OFF_MEM_PWRDN:   next_readdata[7:0] = memory_power_down;
         default:              next_readdata = '0;             // [RULE16]
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= 32'h00000000;
         avs_response <= 2'h0;
      end else if (state == scb_pkg::SCB_IDLE && (avs_read || avs_write)) begin
         avs_readdata <= avs_read ? next_readdata : 32'h00000000;
         // unmapped offsets answer decode error
         avs_response <= hit ? 2'h0 : 2'h3;
      end
   end

   // debug steering from the force register
   assign dbg1.attach    = dbg_ctl[7];                         // [RULE9]
   assign dbg1.clk_drive = dbg_ctl[6];                         // [RULE10]
   assign dbg1.din_drive = dbg_ctl[5];                         // [RULE11]
   assign dbg1.pad_clk   = pad1_debug_clock;
   assign dbg1.pad_din   = pad1_debug_data_in;
   assign dbg0.attach    = dbg_ctl[3];                         // [RULE13]
   assign dbg0.clk_drive = dbg_ctl[2];                         // [RULE13]
   assign dbg0.din_drive = dbg_ctl[1];                         // [RULE13]
   assign dbg0.pad_clk   = pad0_debug_clock;
   assign dbg0.pad_din   = pad0_debug_data_in;
   assign core1_debug_clock   = dbg1.core_clk;
   assign core1_debug_data_in = dbg1.core_din;
   assign core0_debug_clock   = dbg0.core_clk;
   assign core0_debug_data_in = dbg0.core_din;

   scb_debug_mux u_dbg1 (
      .clock  (clock),
      .resetn (resetn),
      .dbg    (dbg1.mux)
   );

   scb_debug_mux u_dbg0 (
      .clock  (clock),
      .resetn (resetn),
      .dbg    (dbg0.mux)
   );

   // software should leave bypass off unless pins are synchronous [RULE8]
   scb_gpio_sync u_sync (
      .clock   (clock),
      .resetn  (resetn),
      .pin_in  (gpio_pin_in),
      .bypass  ({bypass_high, bypass_low}),
      .gpio_in (gpio_in_value)
   );
endmodule // scb_bank
`default_nettype wire

// >>> tb/scb_core_model.sv
// behavioural model of the two cores behind the bank
`timescale 1ns/1ps
`default_nettype none
module scb_core_model (
   // reset
   input  wire logic       resetn,
   // halt levels from the bench
   input  wire logic [1:0] halt_req,
   // debug ports from the bank
   input  wire logic       core0_debug_clock,
   input  wire logic       core0_debug_data_in,
   input  wire logic       core1_debug_clock,
   input  wire logic       core1_debug_data_in,
   // status back to the bank
   output logic            core0_halted,
   output logic            core1_halted,
   output logic            core0_debug_data_out,
   output logic            core1_debug_data_out
);
   assign core0_halted = halt_req[0];
   assign core1_halted = halt_req[1];
   // data out echoes data in taken at each debug clock rise
   always_ff @(posedge core0_debug_clock or negedge resetn) begin
      if (!resetn) core0_debug_data_out <= 1'b0;
      else core0_debug_data_out <= core0_debug_data_in;
   end
   always_ff @(posedge core1_debug_clock or negedge resetn) begin
      if (!resetn) core1_debug_data_out <= 1'b0;
      else core1_debug_data_out <= core1_debug_data_in;
   end
endmodule // scb_core_model
`default_nettype wire

// >>> tb/scb_bank_sva.sv
// timing and read-back checks on the bank ports
`timescale 1ns/1ps
`default_nettype none
module scb_bank_sva (
   // clock and reset
   input wire logic        clock,
   input wire logic        resetn,
   // bus
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic [1:0]  avs_response,
   input wire logic        avs_waitrequest,
   // outputs, and the gpio pin inputs
   input wire logic [3:0]  core1_debug_instance_id,
   input wire logic [35:0] gpio_pin_in,
   input wire logic [35:0] gpio_in_value,
   input wire logic [31:0] core0_nmi_source_mask,
   input wire logic [7:0]  memory_power_down
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // sync flops start at 0, so history is trusted only after three edges
   logic [1:0] warm;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) warm <= 2'h0;
      else if (warm != 2'h3) warm <= warm + 2'h1;
   end
   sequence s_rd(logic [7:0] a);
      !avs_waitrequest && avs_read && avs_address == a;
   endsequence
   sequence s_wr(logic [7:0] a);
      !avs_waitrequest && avs_write && avs_address == a;
   endsequence
   a_wait_gap: assert property (!avs_waitrequest |=> avs_waitrequest [*2])
      else $error("answer not followed by two wait cycles");
   a_answer_bound: assert property ((avs_read || avs_write) && avs_waitrequest
      |-> ##[0:3] !avs_waitrequest) else $error("answer late");
   a_unmapped_zero: assert property (s_rd(8'h1C) |->
      avs_response == 2'h3 && avs_readdata == 32'h0)
      else $error("unmapped read wrong");
   a_id_readback: assert property (s_rd(8'h08) |->
      avs_readdata[23:2] == 22'h0 &&
      avs_readdata[31:28] == core1_debug_instance_id)
      else $error("config read wrong");
   a_nmi_readback: assert property (s_rd(8'h00) |->
      avs_readdata == core0_nmi_source_mask)
      else $error("mask read wrong");
   a_mem_readback: assert property (s_rd(8'h18) |->
      avs_readdata == {24'h0, memory_power_down})
      else $error("power read wrong");
   a_id_write_only: assert property (
      !$stable(core1_debug_instance_id) |-> s_wr(8'h08))
      else $error("id moved without write");
   a_mem_write_only: assert property (
      !$stable(memory_power_down) |-> s_wr(8'h18))
      else $error("power moved without write");
   a_gpio_latency: assert property (warm == 2'h3 |->
      ((gpio_in_value ^ $past(gpio_pin_in, 1)) &
      (gpio_in_value ^ $past(gpio_pin_in, 3))) == 36'h0)
      else $error("gpio latency wrong");
endmodule // scb_bank_sva
bind scb_bank scb_bank_sva i_scb_bank_sva (.clock, .resetn, .avs_address,
   .avs_read, .avs_write, .avs_readdata, .avs_response, .avs_waitrequest,
   .core1_debug_instance_id, .gpio_pin_in, .gpio_in_value,
   .core0_nmi_source_mask, .memory_power_down);
`default_nettype wire

// >>> tb/test_scb_bank.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_scb_bank;
   logic        clock = 1'b0, resetn = 1'b0;
   logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [7:0]  avs_address = 8'h00, memory_power_down;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [1:0]  avs_response, resp, halt_req = 2'h0;
   logic [31:0] core0_nmi_source_mask, core1_nmi_source_mask;
   logic        core0_halted, core1_halted;
   logic        core0_debug_data_out, core1_debug_data_out;
   logic        pad0_debug_clock = 1'b1, pad0_debug_data_in = 1'b1;
   logic        pad1_debug_clock = 1'b1, pad1_debug_data_in = 1'b1;
   logic        core0_debug_clock, core0_debug_data_in;
   logic        core1_debug_clock, core1_debug_data_in;
   logic [3:0]  core0_debug_instance_id, core1_debug_instance_id;
   logic [35:0] gpio_pin_in = 36'h0, gpio_in_value;
   int          err_count = 0, compares = 0, cycles = 0;
   scb_bank i_scb_bank (.clock, .resetn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response,
      .avs_waitrequest, .core0_halted, .core1_halted, .core0_debug_data_out,
      .core1_debug_data_out, .pad0_debug_clock, .pad0_debug_data_in,
      .pad1_debug_clock, .pad1_debug_data_in, .core0_debug_clock,
      .core0_debug_data_in, .core1_debug_clock, .core1_debug_data_in,
      .core0_debug_instance_id, .core1_debug_instance_id, .gpio_pin_in,
      .gpio_in_value, .core0_nmi_source_mask, .core1_nmi_source_mask,
      .memory_power_down);
   scb_core_model i_scb_core_model (.resetn, .halt_req, .core0_debug_clock,
      .core0_debug_data_in, .core1_debug_clock, .core1_debug_data_in,
      .core0_halted, .core1_halted, .core0_debug_data_out,
      .core1_debug_data_out);
   initial begin
      forever #12.5 clock = ~clock;
   end
   task automatic conclude;
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         conclude;
      end
   end
   task automatic check(input string what, input logic [63:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      @(posedge clock);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= !wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      resp = avs_response;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hF);
      check("readdata", rd, exp);
   endtask
   task automatic t_reset_values;
      check("ids", {core1_debug_instance_id, core0_debug_instance_id},
            8'h10);
      check("masks", {core1_nmi_source_mask, core0_nmi_source_mask},
            64'h0);
      check("power", memory_power_down, 8'h00);
      check("dbg reset", {core1_debug_clock, core1_debug_data_in,
            core0_debug_clock, core0_debug_data_in}, 4'hF);
      check("gpio reset", gpio_in_value, 36'h0);
      rchk(8'h04, 32'h0);
      rchk(8'h08, 32'h10000000);
      rchk(8'h0C, 32'h0);
      rchk(8'h10, 32'h0);
      rchk(8'h14, 32'h66);
      rchk(8'h1C, 32'h0);
      check("response", resp, 2'h3);
   endtask
   task automatic t_write_mask;
      bus(1'b1, 8'h00, 32'hFFFFFFFF, 4'hF);
      bus(1'b1, 8'h00, 32'h0, 4'h5);
      rchk(8'h00, 32'hFF00FF00);
      check("response", resp, 2'h0);
      bus(1'b1, 8'h04, 32'hA5C3, 4'hF);
      check("mask1", core1_nmi_source_mask, 32'hA5C3);
      // ids kept away from the reserved value
      bus(1'b1, 8'h08, 32'hEEFFFFFF, 4'hF);
      rchk(8'h08, 32'hEE000000);
      bus(1'b1, 8'h08, 32'h0, 4'h7);
      rchk(8'h08, 32'hEE000000);
      bus(1'b1, 8'h0C, 32'hFFFFFFFF, 4'hF);
      rchk(8'h0C, 32'h3FFFFFFF);
      bus(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF);
      rchk(8'h10, 32'h3F);
      bus(1'b1, 8'h18, 32'hFFFFFF81, 4'hF);
      rchk(8'h18, 32'h81);
      bus(1'b1, 8'h18, 32'h7E, 4'hF);
      check("power", memory_power_down, 8'h7E);
      bus(1'b1, 8'h0C, 32'h0, 4'hF);
      bus(1'b1, 8'h10, 32'h0, 4'hF);
   endtask
   task automatic t_debug;
      bus(1'b1, 8'h14, 32'h88, 4'hF);
      @(negedge clock);
      check("attached", {core1_debug_clock, core1_debug_data_in,
            core0_debug_clock, core0_debug_data_in}, 4'h0);
      // data first, clock edge after, so the core sees a settled input
      bus(1'b1, 8'h14, 32'hAA, 4'hF);
      bus(1'b1, 8'h14, 32'hFFFFFFEE, 4'hF);
      repeat (4) @(posedge clock);
      rchk(8'h14, 32'hFF);
      pad0_debug_clock   <= 1'b0;
      pad1_debug_data_in <= 1'b0;
      // attached ports must ignore the pads
      repeat (2) @(negedge clock);
      check("held", {core1_debug_clock, core1_debug_data_in,
            core0_debug_clock, core0_debug_data_in}, 4'hF);
      bus(1'b1, 8'h14, 32'h66, 4'hF);
      @(negedge clock);
      check("pads", {core1_debug_clock, core1_debug_data_in,
            core0_debug_clock, core0_debug_data_in}, 4'h9);
   endtask
   task automatic t_halt;
      @(posedge clock);
      halt_req <= 2'h2;
      repeat (3) @(posedge clock);
      rchk(8'h08, 32'hEE000002);
      halt_req <= 2'h1;
      repeat (3) @(posedge clock);
      rchk(8'h08, 32'hEE000001);
   endtask
   task automatic t_gpio;
      bus(1'b1, 8'h0C, 32'h1, 4'hF);
      bus(1'b1, 8'h10, 32'h1, 4'hF);
      @(posedge clock);
      gpio_pin_in <= {36{1'b1}};
      repeat (2) @(negedge clock);
      check("gpio", gpio_in_value, 36'h040000001);
      @(negedge clock);
      check("gpio", gpio_in_value, 36'h040000001);
      @(negedge clock);
      check("gpio", gpio_in_value, {36{1'b1}});
   endtask
   initial begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset_values;
      t_write_mask;
      t_debug;
      t_halt;
      t_gpio;
      conclude;
   end
endmodule // test_scb_bank
`default_nettype wire
